// ==== shared/tpwm_pkg.sv ====
package tpwm_pkg;

    // register byte offsets, one aligned 32-bit word each
    localparam logic [7:0] OFS_CTRL_A = 8'h24;
    localparam logic [7:0] OFS_CTRL_B = 8'h28;
    localparam logic [7:0] OFS_COUNT = 8'h2C;
    localparam logic [7:0] OFS_CMP_A = 8'h30;
    localparam logic [7:0] OFS_CMP_B = 8'h34;
    localparam logic [7:0] OFS_FLAGS = 8'h38;
    localparam logic [7:0] OFS_PORT = 8'h3C;

    // control register a layout, msb first
    typedef struct packed {
        logic [1:0] output_mode_a;
        logic [1:0] output_mode_b;
        logic [1:0] rsvd;
        logic [1:0] wgm_lo;
    } tpwm_ctrl_a_t;

    // control register b field positions
    localparam int unsigned CB_WGM_HI_POS = 3;
    localparam int unsigned CB_CS_MSB = 2;

    // flag register bit positions, write one to clear
    localparam int unsigned FLAG_OVF_POS = 0;
    localparam int unsigned FLAG_MA_POS = 1;
    localparam int unsigned FLAG_MB_POS = 2;

    // port register bit positions
    localparam int unsigned PORT_DIR_A_POS = 0;
    localparam int unsigned PORT_DIR_B_POS = 1;
    localparam int unsigned PORT_DAT_A_POS = 4;
    localparam int unsigned PORT_DAT_B_POS = 5;

    // reset values
    localparam logic [7:0] CTRL_A_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // count landmarks
    localparam logic [7:0] MAX_VAL = 8'hFF;
    localparam logic [7:0] BOTTOM_VAL = 8'h00;
    localparam logic [7:0] CNT_STEP = 8'h01;

    // ticks in one phase correct period with a fixed turnaround
    localparam int unsigned PC_PERIOD_TICKS = 510;

    typedef enum logic [2:0] {
        WGM_NORMAL = 3'h0,
        WGM_PC_MAX = 3'h1,
        WGM_CTC = 3'h2,
        WGM_FAST_MAX = 3'h3,
        WGM_RSVD4 = 3'h4,
        WGM_PC_CMP = 3'h5,
        WGM_RSVD6 = 3'h6,
        WGM_FAST_CMP = 3'h7
    } tpwm_wgm_t;

    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;

    // clock source select codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;

    // prescaler terminal counts, divide factor minus one
    localparam logic [9:0] PRE_TC8 = 10'h007;
    localparam logic [9:0] PRE_TC64 = 10'h03F;
    localparam logic [9:0] PRE_TC256 = 10'h0FF;
    localparam logic [9:0] PRE_TC1024 = 10'h3FF;

    typedef enum logic [1:0] {
        DIR_UP = 2'b01,
        DIR_DOWN = 2'b10
    } tpwm_dir_t;

endpackage

// ==== hw/tpwm_prescaler.sv ====
`timescale 1ns/100ps
module tpwm_prescaler (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] clock_source_select_i,
    output logic timer_tick_enable_o
);
    logic [9:0] div_reg;
    logic tick_next;

    // free running so a change of source needs no restart
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_reg <= 10'h000;
        end else begin
            div_reg <= div_reg + 10'h001;
        end
    end

    always_comb begin
        tick_next = 1'b0;
        unique case (clock_source_select_i)
            tpwm_pkg::CS_DIV1: tick_next = 1'b1;
            tpwm_pkg::CS_DIV8:
                tick_next = (div_reg & tpwm_pkg::PRE_TC8) == tpwm_pkg::PRE_TC8;
            tpwm_pkg::CS_DIV64:
                tick_next = (div_reg & tpwm_pkg::PRE_TC64)
                    == tpwm_pkg::PRE_TC64;
            tpwm_pkg::CS_DIV256:
                tick_next = (div_reg & tpwm_pkg::PRE_TC256)
                    == tpwm_pkg::PRE_TC256;
            tpwm_pkg::CS_DIV1024: tick_next = div_reg == tpwm_pkg::PRE_TC1024;
            // stop code and external codes give no tick
            default: tick_next = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_tick_enable_o <= 1'b0;
        end else begin
            timer_tick_enable_o <= tick_next;
        end
    end
endmodule

// ==== hw/tpwm_top.sv ====
// The Wishbone register port was decided locally.
`timescale 1ns/100ps
module tpwm_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic wave_out_a_o,
    output logic wave_out_b_o,
    output logic pin_a_o,
    output logic pin_a_oe_o,
    output logic pin_b_o,
    output logic pin_b_oe_o,
    output logic overflow_flag_o
);
    tpwm_pkg::tpwm_ctrl_a_t ctrl_a_reg;
    logic wgm_hi_reg;
    logic [2:0] cs_reg;
    logic [7:0] cnt_reg;
    logic [7:0] cmp_a_buf_reg;
    logic [7:0] cmp_a_reg;
    logic [7:0] cmp_b_buf_reg;
    logic [7:0] cmp_b_reg;
    tpwm_pkg::tpwm_dir_t dir_reg;
    logic ovf_reg;
    logic mfa_reg;
    logic mfb_reg;
    logic wave_a_reg;
    logic wave_b_reg;
    logic missed_a_reg;
    logic missed_b_reg;
    logic dir_a_reg;
    logic dir_b_reg;
    logic dat_a_reg;
    logic dat_b_reg;
    logic [31:0] rd_data;
    logic tick;
    tpwm_pkg::tpwm_wgm_t wgm;
    logic is_pc;
    logic is_fast;
    logic is_pwm;
    logic [7:0] top_val;
    logic wr;
    logic cnt_wr;
    logic flag_wr;
    logic at_top;
    logic at_bottom;
    logic eff_down;
    logic match_a;
    logic match_b;
    logic ovf_set;

    // next level of one wave output
    function automatic logic wave_next(
        input logic is_a,
        input tpwm_pkg::tpwm_wgm_t mode,
        input logic [1:0] com,
        input logic cur,
        input logic match,
        input logic top_hit,
        input logic bottom_hit,
        input logic down,
        input logic cmp_top,
        input logic missed
    );
        logic nxt;
        logic up_lvl;
        logic pc;
        logic fast;
        nxt = cur;
        up_lvl = (com == tpwm_pkg::COM_SET);
        pc = (mode == tpwm_pkg::WGM_PC_MAX) || (mode == tpwm_pkg::WGM_PC_CMP);
        fast = (mode == tpwm_pkg::WGM_FAST_MAX)
            || (mode == tpwm_pkg::WGM_FAST_CMP);
        if (com == tpwm_pkg::COM_OFF) begin
            nxt = cur;
        end else if (pc || fast) begin
            if (com == tpwm_pkg::COM_TOGGLE) begin
                if (is_a && mode[2] && match) begin
                    nxt = ~cur;
                end
            end else if (cmp_top) begin
                if (top_hit) begin
                    nxt = pc ? ~up_lvl : (com == tpwm_pkg::COM_CLEAR);
                end
            end else if (pc) begin
                if (match) begin
                    nxt = down ? ~up_lvl : up_lvl;
                end
                if (bottom_hit && missed) begin
                    nxt = up_lvl;
                end
            end else begin
                if (match) begin
                    nxt = up_lvl;
                end else if (top_hit) begin
                    nxt = (com == tpwm_pkg::COM_CLEAR);
                end
            end
        end else begin
            if (match) begin
                nxt = (com == tpwm_pkg::COM_TOGGLE) ? ~cur : up_lvl;
            end
        end
        return nxt;
    endfunction

    // whether the wave owns the pin instead of port data
    function automatic logic wave_owns_pin(
        input logic is_a,
        input tpwm_pkg::tpwm_wgm_t mode,
        input logic [1:0] com
    );
        logic pwm;
        pwm = (mode == tpwm_pkg::WGM_PC_MAX) || (mode == tpwm_pkg::WGM_PC_CMP)
            || (mode == tpwm_pkg::WGM_FAST_MAX)
            || (mode == tpwm_pkg::WGM_FAST_CMP);
        if (com == tpwm_pkg::COM_OFF) begin
            return 1'b0;
        end
        if (pwm && com == tpwm_pkg::COM_TOGGLE) begin
            return is_a && mode[2];
        end
        return 1'b1;
    endfunction

    tpwm_prescaler u_prescaler (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clock_source_select_i(cs_reg),
        .timer_tick_enable_o(tick)
    );

    assign wgm = tpwm_pkg::tpwm_wgm_t'({wgm_hi_reg, ctrl_a_reg.wgm_lo});
    assign is_pc = (wgm == tpwm_pkg::WGM_PC_MAX)
        || (wgm == tpwm_pkg::WGM_PC_CMP);
    assign is_fast = (wgm == tpwm_pkg::WGM_FAST_MAX)
        || (wgm == tpwm_pkg::WGM_FAST_CMP);
    assign is_pwm = is_pc || is_fast;
    assign top_val = ((wgm == tpwm_pkg::WGM_PC_CMP)
        || (wgm == tpwm_pkg::WGM_FAST_CMP) || (wgm == tpwm_pkg::WGM_CTC))
        ? cmp_a_reg : tpwm_pkg::MAX_VAL;

    assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
    assign cnt_wr = wr && (adr_i == tpwm_pkg::OFS_COUNT);
    assign flag_wr = wr && (adr_i == tpwm_pkg::OFS_FLAGS);

    // tick is the only enable; no logic runs on a derived clock
    assign at_top = tick && (cnt_reg == top_val);
    assign at_bottom = tick && is_pc && (dir_reg == tpwm_pkg::DIR_DOWN)
        && (cnt_reg == tpwm_pkg::BOTTOM_VAL);
    // the zero tick belongs to the rising slope
    assign eff_down = (dir_reg == tpwm_pkg::DIR_DOWN)
        && (cnt_reg != tpwm_pkg::BOTTOM_VAL);
    assign match_a = tick && (cnt_reg == cmp_a_reg);
    assign match_b = tick && (cnt_reg == cmp_b_reg);
    assign ovf_set = tick && !cnt_wr && (is_pc
        ? (dir_reg == tpwm_pkg::DIR_DOWN && cnt_reg == tpwm_pkg::CNT_STEP)
        : (cnt_reg == ((wgm == tpwm_pkg::WGM_FAST_CMP)
            ? top_val : tpwm_pkg::MAX_VAL)));

    // counter and direction; a software write beats the tick
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= tpwm_pkg::BYTE_RST;
            dir_reg <= tpwm_pkg::DIR_UP;
        end else if (cnt_wr) begin
            cnt_reg <= dat_i[7:0];
        end else if (tick) begin
            if (is_pc) begin
                unique case (dir_reg)
                    tpwm_pkg::DIR_UP: begin
                        // a count above top still turns at max, no wrap
                        if (cnt_reg == top_val
                            || cnt_reg == tpwm_pkg::MAX_VAL) begin
                            dir_reg <= tpwm_pkg::DIR_DOWN;
                            cnt_reg <= (cnt_reg == tpwm_pkg::BOTTOM_VAL)
                                ? cnt_reg : cnt_reg - tpwm_pkg::CNT_STEP;
                        end else begin
                            cnt_reg <= cnt_reg + tpwm_pkg::CNT_STEP;
                        end
                    end
                    tpwm_pkg::DIR_DOWN: begin
                        if (cnt_reg == tpwm_pkg::BOTTOM_VAL) begin
                            dir_reg <= tpwm_pkg::DIR_UP;
                            cnt_reg <= (top_val == tpwm_pkg::BOTTOM_VAL)
                                ? cnt_reg : cnt_reg + tpwm_pkg::CNT_STEP;
                        end else begin
                            cnt_reg <= cnt_reg - tpwm_pkg::CNT_STEP;
                        end
                    end
                endcase
            end else begin
                dir_reg <= tpwm_pkg::DIR_UP;
                if ((is_fast || wgm == tpwm_pkg::WGM_CTC)
                    && cnt_reg == top_val) begin
                    cnt_reg <= tpwm_pkg::BOTTOM_VAL;
                end else begin
                    cnt_reg <= cnt_reg + tpwm_pkg::CNT_STEP;
                end
            end
        end
    end

    // control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_a_reg <= tpwm_pkg::CTRL_A_RST;
            wgm_hi_reg <= 1'b0;
            cs_reg <= tpwm_pkg::CS_STOP;
            dir_a_reg <= 1'b0;
            dir_b_reg <= 1'b0;
            dat_a_reg <= 1'b0;
            dat_b_reg <= 1'b0;
        end else if (wr) begin
            if (adr_i == tpwm_pkg::OFS_CTRL_A) begin
                ctrl_a_reg <= dat_i[7:0];
                ctrl_a_reg.rsvd <= 2'h0;
            end
            if (adr_i == tpwm_pkg::OFS_CTRL_B) begin
                wgm_hi_reg <= dat_i[tpwm_pkg::CB_WGM_HI_POS];
                cs_reg <= dat_i[tpwm_pkg::CB_CS_MSB:0];
            end
            if (adr_i == tpwm_pkg::OFS_PORT) begin
                dir_a_reg <= dat_i[tpwm_pkg::PORT_DIR_A_POS];
                dir_b_reg <= dat_i[tpwm_pkg::PORT_DIR_B_POS];
                dat_a_reg <= dat_i[tpwm_pkg::PORT_DAT_A_POS];
                dat_b_reg <= dat_i[tpwm_pkg::PORT_DAT_B_POS];
            end
        end
    end

    // compare buffers: immediate outside pwm, loaded at top inside
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmp_a_buf_reg <= tpwm_pkg::BYTE_RST;
            cmp_b_buf_reg <= tpwm_pkg::BYTE_RST;
            cmp_a_reg <= tpwm_pkg::BYTE_RST;
            cmp_b_reg <= tpwm_pkg::BYTE_RST;
        end else begin
            if (wr && adr_i == tpwm_pkg::OFS_CMP_A) begin
                cmp_a_buf_reg <= dat_i[7:0];
            end
            if (wr && adr_i == tpwm_pkg::OFS_CMP_B) begin
                cmp_b_buf_reg <= dat_i[7:0];
            end
            if (!is_pwm || at_top) begin
                cmp_a_reg <= cmp_a_buf_reg;
                cmp_b_reg <= cmp_b_buf_reg;
            end
        end
    end

    // missed up-slope level, set wins over the bottom clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            missed_a_reg <= 1'b0;
            missed_b_reg <= 1'b0;
        end else begin
            missed_a_reg <= (is_pc && ((at_top && cmp_a_reg == top_val
                && cmp_a_buf_reg != top_val)
                || (cnt_wr && dir_reg == tpwm_pkg::DIR_UP
                && dat_i[7:0] > cmp_a_reg)))
                || (missed_a_reg && !at_bottom);
            missed_b_reg <= (is_pc && ((at_top && cmp_b_reg == top_val
                && cmp_b_buf_reg != top_val)
                || (cnt_wr && dir_reg == tpwm_pkg::DIR_UP
                && dat_i[7:0] > cmp_b_reg)))
                || (missed_b_reg && !at_bottom);
        end
    end

    // sticky flags, write one to clear, a new event wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ovf_reg <= 1'b0;
            mfa_reg <= 1'b0;
            mfb_reg <= 1'b0;
        end else begin
            ovf_reg <= ovf_set
                || (ovf_reg && !(flag_wr && dat_i[tpwm_pkg::FLAG_OVF_POS]));
            mfa_reg <= (match_a && !cnt_wr)
                || (mfa_reg && !(flag_wr && dat_i[tpwm_pkg::FLAG_MA_POS]));
            mfb_reg <= (match_b && !cnt_wr)
                || (mfb_reg && !(flag_wr && dat_i[tpwm_pkg::FLAG_MB_POS]));
        end
    end

    // wave generators; a count write suppresses that tick's compare
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wave_a_reg <= 1'b0;
            wave_b_reg <= 1'b0;
        end else if (!cnt_wr) begin
            wave_a_reg <= wave_next(1'b1, wgm, ctrl_a_reg.output_mode_a,
                wave_a_reg, match_a, at_top, at_bottom, eff_down,
                cmp_a_reg == top_val, missed_a_reg);
            wave_b_reg <= wave_next(1'b0, wgm, ctrl_a_reg.output_mode_b,
                wave_b_reg, match_b, at_top, at_bottom, eff_down,
                cmp_b_reg == top_val, missed_b_reg);
        end
    end

    // pin mux registered so every output is a flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_a_o <= 1'b0;
            pin_b_o <= 1'b0;
            pin_a_oe_o <= 1'b0;
            pin_b_oe_o <= 1'b0;
            wave_out_a_o <= 1'b0;
            wave_out_b_o <= 1'b0;
            overflow_flag_o <= 1'b0;
        end else begin
            pin_a_o <= wave_owns_pin(1'b1, wgm, ctrl_a_reg.output_mode_a)
                ? wave_a_reg : dat_a_reg;
            pin_b_o <= wave_owns_pin(1'b0, wgm, ctrl_a_reg.output_mode_b)
                ? wave_b_reg : dat_b_reg;
            pin_a_oe_o <= dir_a_reg;
            pin_b_oe_o <= dir_b_reg;
            wave_out_a_o <= wave_a_reg;
            wave_out_b_o <= wave_b_reg;
            overflow_flag_o <= ovf_reg;
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        unique case (adr_i)
            tpwm_pkg::OFS_CTRL_A: rd_data[7:0] = ctrl_a_reg;
            tpwm_pkg::OFS_CTRL_B:
                rd_data[3:0] = {wgm_hi_reg, cs_reg};
            tpwm_pkg::OFS_COUNT: rd_data[7:0] = cnt_reg;
            tpwm_pkg::OFS_CMP_A: rd_data[7:0] = cmp_a_buf_reg;
            tpwm_pkg::OFS_CMP_B: rd_data[7:0] = cmp_b_buf_reg;
            tpwm_pkg::OFS_FLAGS: rd_data[2:0] = {mfb_reg, mfa_reg, ovf_reg};
            tpwm_pkg::OFS_PORT:
                rd_data[5:0] = {dat_b_reg,dat_a_reg,2'h0,dir_b_reg,dir_a_reg};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    // one wait state; unmapped addresses still answer, reading zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
            if (cyc_i && stb_i && !ack_o) begin
                dat_o <= rd_data;
            end
        end
    end
endmodule

// ==== sim/tpwm_pin_model.sv ====
`timescale 1ns/100ps
module tpwm_pin_model (
    input wire logic clk_i,
    input wire logic drv_i,
    input wire logic oe_i,
    output logic level_o
);
    logic last_reg = 1'b0;
    always @(posedge clk_i) begin
        if (oe_i) begin
            last_reg <= drv_i;
        end
    end
    // undriven pin does not float: shows the inverse of its last driven level
    assign level_o = oe_i ? drv_i : ~last_reg;
endmodule

// ==== sim/tpwm_chk.sv ====
`timescale 1ns/100ps
module tpwm_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic wave_out_a_o,
    input wire logic pin_a_o,
    input wire logic pin_a_oe_o,
    input wire logic overflow_flag_o
);
    logic req;
    logic flag_wr;
    logic port_wr;
    assign req = cyc_i && stb_i;
    assign flag_wr = req && we_i && sel_i[0] && dat_i[0]
        && adr_i == tpwm_pkg::OFS_FLAGS;
    assign port_wr = req && we_i && sel_i[0] && adr_i == tpwm_pkg::OFS_PORT;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ack_timing_a: assert property (req && !ack_o |=> ack_o)
        else $error("ack late");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held");
    ack_cause_a: assert property (ack_o |-> $past(req))
        else $error("ack without request");
    reset_clear_a: assert property ($fell(rst_i) |->
        !(ack_o || overflow_flag_o || pin_a_oe_o || pin_a_o || wave_out_a_o))
        else $error("outputs not clear after reset");
    ctrl_rsvd_a: assert property (ack_o &&
        $past(!we_i && adr_i == tpwm_pkg::OFS_CTRL_A)
        |-> dat_o[31:8] == 24'h00_0000 && dat_o[3:2] == 2'b00)
        else $error("control a reserved bits set");
    unmapped_read_a: assert property (ack_o && $past(!we_i && adr_i == 8'h00)
        |-> dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    flag_sticky_a: assert property ($fell(overflow_flag_o) |->
        $past(flag_wr) || $past(flag_wr, 2))
        else $error("overflow flag lost");
    oe_cause_a: assert property ($changed(pin_a_oe_o) |->
        $past(port_wr) || $past(port_wr, 2))
        else $error("driver enable moved");
    dat_hold_a: assert property ($changed(dat_o) |-> ack_o)
        else $error("read data moved");
endmodule
bind tpwm_top tpwm_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .wave_out_a_o, .pin_a_o, .pin_a_oe_o,
    .overflow_flag_o);

// ==== sim/tpwm_top_test.sv ====
`timescale 1ns/100ps
module tpwm_top_test;
    typedef struct packed {logic [7:0] adr, wd, rv;} tpwm_row_t;
    typedef struct packed {logic [7:0] ca, cb, cm; int ep, eh;} tpwm_ms_t;
    typedef struct packed {logic [7:0] ca, cm, pt; logic ev;} tpwm_st_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o, rd, saved;
    logic ack_o, wave_out_a_o, wave_out_b_o, pin_a_o, pin_a_oe_o;
    logic pin_b_o, pin_b_oe_o, overflow_flag_o, lvl;
    int failures = 0;
    int n_tests = 0;
    int cycles = 0;
    int hi, per, bad;
    tpwm_row_t rows [7] = '{'{8'h24, 8'hFF, 8'hF3}, '{8'h28, 8'hF8, 8'h08},
        '{8'h2C, 8'h77, 8'h77}, '{8'h30, 8'h5A, 8'h5A},
        '{8'h34, 8'hA5, 8'hA5}, '{8'h00, 8'hFF, 8'h00},
        '{8'h3C, 8'h33, 8'h33}};
    // high time of -1: not checked, edge placement left open
    tpwm_ms_t ms [6] = '{'{8'hA1, 8'h01, 8'h40, 510, 128},
        '{8'hE1, 8'h01, 8'h40, 510, 382}, '{8'hA1, 8'h02, 8'h40, 4080, 1024},
        '{8'h41, 8'h09, 8'h80, 512, 256}, '{8'h40, 8'h01, 8'h40, 512, 256},
        '{8'hA3, 8'h01, 8'h40, 256, -1}};
    tpwm_st_t st [5] = '{'{8'hA1, 8'h00, 8'h01, 1'b0},
        '{8'hA1, 8'hFF, 8'h01, 1'b1}, '{8'hE1, 8'h00, 8'h01, 1'b1},
        '{8'h41, 8'h40, 8'h11, 1'b1}, '{8'h01, 8'h40, 8'h11, 1'b1}};

    tpwm_top u_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i,
        .dat_i, .dat_o, .ack_o, .wave_out_a_o, .wave_out_b_o, .pin_a_o,
        .pin_a_oe_o, .pin_b_o, .pin_b_oe_o, .overflow_flag_o);
    tpwm_pin_model u_pin (.clk_i, .drv_i(pin_a_o), .oe_i(pin_a_oe_o),
        .level_o(lvl));

    always #2 clk_i = ~clk_i;

    task automatic give_verdict();
        $display("compared %0d, failed %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 90000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // entered just after a clock edge; answer taken at the ack edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'h1;
        dat_i <= {24'h00_0000, d};
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // stop and clear count first so a mode change starts clean
    task automatic cfg(input logic [7:0] ca, cb, cm, pt);
        wb(1'b1, tpwm_pkg::OFS_CTRL_B, 8'h00);
        wb(1'b1, tpwm_pkg::OFS_CTRL_A, 8'h00);
        wb(1'b1, tpwm_pkg::OFS_COUNT, 8'h00);
        wb(1'b1, tpwm_pkg::OFS_CMP_A, cm);
        wb(1'b1, tpwm_pkg::OFS_PORT, pt);
        wb(1'b1, tpwm_pkg::OFS_CTRL_A, ca);
        wb(1'b1, tpwm_pkg::OFS_CTRL_B, cb);
    endtask

    // skip one full cycle of transients, then time the next one
    task automatic measure();
        hi = 0;
        while (lvl !== 1'b0) @(posedge clk_i);
        while (lvl !== 1'b1) @(posedge clk_i);
        while (lvl !== 1'b0) @(posedge clk_i);
        while (lvl !== 1'b1) @(posedge clk_i);
        while (lvl === 1'b1) @(posedge clk_i) hi++;
        per = hi;
        while (lvl === 1'b0) @(posedge clk_i) per++;
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        check({ack_o, pin_a_oe_o, pin_a_o, overflow_flag_o}, 4'h0);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (rows[i]) begin
            wb(1'b0, rows[i].adr, 8'h00);
            check(rd, 32'h0000_0000);
            wb(1'b1, rows[i].adr, rows[i].wd);
            wb(1'b0, rows[i].adr, 8'h00);
            check(rd, {24'h00_0000, rows[i].rv});
        end
        $display("test registers done");
        foreach (ms[i]) begin
            cfg(ms[i].ca, ms[i].cb, ms[i].cm, 8'h01);
            measure();
            check(per, ms[i].ep);
            if (ms[i].eh >= 0) begin
                check(hi, ms[i].eh);
            end
        end
        $display("test periods done");
        foreach (st[i]) begin
            cfg(st[i].ca, 8'h01, st[i].cm, st[i].pt);
            repeat (1100) @(posedge clk_i);
            bad = 0;
            repeat (600) @(posedge clk_i) if (lvl !== st[i].ev) bad++;
            check(bad, 0);
        end
        $display("test steady levels done");
        cfg(8'hA1, 8'h01, 8'hFF, 8'h01);
        repeat (600) @(posedge clk_i);
        wb(1'b1, tpwm_pkg::OFS_CMP_A, 8'h40);
        while (lvl !== 1'b0) @(posedge clk_i);
        hi = 0;
        while (lvl === 1'b0) @(posedge clk_i) hi++;
        check(hi, 446);
        cfg(8'h51, 8'h09, 8'h80, 8'h33);
        repeat (600) @(posedge clk_i);
        bad = 0;
        saved = {31'h0000_0000, wave_out_b_o};
        repeat (600) @(posedge clk_i) begin
            if ({pin_b_oe_o, pin_b_o} !== 2'b11) bad++;
            if (wave_out_a_o !== lvl || wave_out_b_o !== saved[0]) bad++;
        end
        check(bad, 0);
        $display("test symmetry and channel b done");
        cfg(8'h01, 8'h01, 8'h40, 8'h01);
        wb(1'b1, tpwm_pkg::OFS_FLAGS, 8'h07);
        repeat (600) @(posedge clk_i);
        check(overflow_flag_o, 1'b1);
        wb(1'b1, tpwm_pkg::OFS_CTRL_B, 8'h00);
        wb(1'b1, tpwm_pkg::OFS_FLAGS, 8'h07);
        wb(1'b0, tpwm_pkg::OFS_COUNT, 8'h00);
        saved = rd;
        repeat (600) @(posedge clk_i);
        wb(1'b0, tpwm_pkg::OFS_COUNT, 8'h00);
        check(rd, saved);
        check(overflow_flag_o, 1'b0);
        $display("test overflow and stop done");
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, tpwm_pkg::OFS_CTRL_A, 8'h00);
        check(rd, 32'h0000_0000);
        check({pin_a_oe_o, pin_b_oe_o, overflow_flag_o}, 3'h0);
        $display("test reset in run done");
        give_verdict();
    end
endmodule
